// ==== verilog/dcil_pkg.sv ====
// Shared constants for the dual-channel interlock logic
`default_nettype none
package dcil_pkg;
	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS  = 10;
	localparam int FLASH_HALF_NS  = 250000000;
	localparam int FLASH_HALF_CYC = FLASH_HALF_NS / CLK_PERIOD_NS;
	localparam int DIAG_BIT_NS    = 10000;
	localparam int DIAG_BIT_CYC   = (DIAG_BIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// Diagnostics frame layout
	// ----------------------------------------
	localparam int DIAG_CMD_W     = 8;
	localparam int DIAG_RSP_W     = 16;
	localparam int DIAG_ADDR_W    = 4;
	localparam int DIAG_MAX_CHAIN = 16;
	localparam int DIAG_TX_BITS   = DIAG_RSP_W + 2;
	localparam int DIAG_RX_BITS   = DIAG_CMD_W + 1;

	localparam logic [3:0] OP_SERIAL = 4'h1;
	localparam logic [3:0] OP_TEACH  = 4'h2;
	localparam logic [3:0] OP_NAME   = 4'h3;
	localparam logic [3:0] OP_STATUS = 4'h4;

	typedef enum logic [1:0] {PL_NORMAL, PL_UNEQUAL, PL_LOCK} dcil_pl_e;
endpackage
`default_nettype wire

// ==== verilog/dcil_diag.sv ====
// Serial diagnostics responder on the diagnostic input and status output
`timescale 1ns/1ns
`default_nettype none
module dcil_diag #(
	parameter int BIT_CYC = dcil_pkg::DIAG_BIT_CYC
) (
	input  wire logic        sys_clk,       // System clock
	input  wire logic        rst,           // Sync reset, restarts link
	input  wire logic        enable,        // Fieldbus module attached
	input  wire logic        diag_in,       // Serial command line, idle high
	input  wire logic [3:0]  chain_addr,    // Position in series chain
	input  wire logic [15:0] serial_num,    // Serial number
	input  wire logic [7:0]  teach_left,    // Teach-ins remaining
	input  wire logic [15:0] actuator_name, // Current actuator name
	input  wire logic [7:0]  sw_status,     // Switching status byte
	output logic             tx_out,        // Serial answer bit
	output logic             tx_active      // Answer in progress
);
	typedef enum logic [1:0] {DG_IDLE, DG_RX, DG_TX} dcil_dg_e;

	dcil_dg_e    st_r;
	logic [15:0] div_r;
	logic [4:0]  cnt_r;
	logic [8:0]  rx_r;
	logic [17:0] tx_r;
	logic [15:0] rsp;
	logic        tick;
	logic        hit;

	// Marker outside the bit count range, so the answer load cannot fire again mid-answer
	localparam logic [4:0] CNT_LOAD = 5'h1F;

	assign tick = (div_r == 16'h0000);
	assign hit  = (rx_r[0] == 1'b0) && (rx_r[8:5] == chain_addr);
	assign rsp  = (rx_r[4:1] == dcil_pkg::OP_SERIAL) ? serial_num :
	              (rx_r[4:1] == dcil_pkg::OP_TEACH)  ? {8'h00, teach_left} :
	              (rx_r[4:1] == dcil_pkg::OP_NAME)   ? actuator_name :
	              {8'h00, sw_status};

	always_ff @(posedge sys_clk)
	begin
		if (rst || !enable)
		begin
			st_r   <= DG_IDLE;
			div_r  <= 16'h0000;
			cnt_r  <= 5'h00;
			rx_r   <= 9'h000;
			tx_r   <= 18'h3FFFF;
			tx_out <= 1'b1;
		end
		else
		begin
			div_r <= tick ? 16'(BIT_CYC - 1) : div_r - 16'h0001;
			case (st_r)
				DG_IDLE:
					if (!diag_in)
					begin
						st_r  <= DG_RX;
						div_r <= 16'(BIT_CYC / 2);
						cnt_r <= 5'h00;
					end
				DG_RX:
					if (tick)
					begin
						rx_r  <= {diag_in, rx_r[8:1]};
						cnt_r <= cnt_r + 5'h01;
						if (cnt_r == 5'(dcil_pkg::DIAG_RX_BITS - 1))
						begin
							st_r  <= DG_TX;
							cnt_r <= CNT_LOAD;
						end
					end
				DG_TX:
					if (!hit)
						st_r <= DG_IDLE;
					else if (cnt_r == CNT_LOAD)
					begin
						tx_r  <= {1'b1, rsp, 1'b0};
						cnt_r <= 5'h00;
					end
					else if (tick)
					begin
						tx_out <= tx_r[0];
						tx_r   <= {1'b1, tx_r[17:1]};
						cnt_r  <= cnt_r + 5'h01;
						if (cnt_r == 5'(dcil_pkg::DIAG_TX_BITS))
							st_r <= DG_IDLE;
					end
				default:
					st_r <= DG_IDLE;
			endcase
		end
	end

	assign tx_active = (st_r == DG_TX) && hit;
endmodule
`default_nettype wire

// ==== verilog/dcil_top.sv ====
// Output and plausibility logic of the dual-channel interlock switch
`timescale 1ns/1ns
`default_nettype none
module dcil_top #(
	parameter int          FLASH_CYC = dcil_pkg::FLASH_HALF_CYC,
	parameter int          BIT_CYC   = dcil_pkg::DIAG_BIT_CYC,
	parameter logic [15:0] SERIAL_NO = 16'h5A5A  // Arbitrary value
) (
	input  wire logic        sys_clk,            // 100 MHz clock
	input  wire logic        rst,                // Sync reset, active high
	input  wire logic        safety_in_ch1,      // Safety input channel 1
	input  wire logic        safety_in_ch2,      // Safety input channel 2
	input  wire logic        actuator_present,   // Actuator in response range
	input  wire logic        device_ready,       // Ready for operation
	input  wire logic        serial_diag_option, // Fieldbus module attached
	input  wire logic        diag_in,            // Diagnostic input
	input  wire logic [3:0]  chain_addr,         // Position in series chain
	input  wire logic [7:0]  teach_left,         // Teach-ins remaining
	input  wire logic [15:0] actuator_name,      // Actuator name
	output logic             safety_out_ch1,     // Safety output channel 1
	output logic             safety_out_ch2,     // Safety output channel 2
	output logic             status_diag_out,    // Status or diagnostic data
	output logic             input_led_flash,    // Input indicator flashing
	output logic             plaus_error,        // Plausibility error
	output logic             diag_in_en          // Diagnostic input in use
);
	// ----------------------------------------
	// Plausibility state
	// ----------------------------------------
	dcil_pkg::dcil_pl_e pl_r;
	dcil_pkg::dcil_pl_e pl_nxt;
	logic        aff_ch2_r;
	logic        aff_ch2_nxt;
	logic        in1_r;
	logic        in2_r;
	logic [24:0] flash_cnt_r;
	logic        blink_r;
	logic        fall1;
	logic        fall2;
	logic        both_low;
	logic        active;
	logic        out1_nxt;
	logic        out2_nxt;
	logic        tx_bit;
	logic        tx_active;
	logic        rst_d_r;

	assign fall1    = in1_r && !safety_in_ch1 && safety_in_ch2;
	assign fall2    = in2_r && !safety_in_ch2 && safety_in_ch1;
	assign both_low = !safety_in_ch1 && !safety_in_ch2;
	assign active   = device_ready && actuator_present;

	always_comb
	begin
		pl_nxt      = pl_r;
		aff_ch2_nxt = aff_ch2_r;
		case (pl_r)
			dcil_pkg::PL_NORMAL:
				if (fall1 || fall2)
				begin
					pl_nxt      = dcil_pkg::PL_UNEQUAL;
					aff_ch2_nxt = fall2;
				end
			dcil_pkg::PL_UNEQUAL:
				if (both_low)
					pl_nxt = dcil_pkg::PL_NORMAL;
				else if (safety_in_ch1 && safety_in_ch2)
					pl_nxt = dcil_pkg::PL_LOCK;
			dcil_pkg::PL_LOCK:
				if (both_low)
					pl_nxt = dcil_pkg::PL_NORMAL;
			default:
				pl_nxt = dcil_pkg::PL_NORMAL;
		endcase
	end

	// Affected channel stays low through the lock
	assign out1_nxt = active && safety_in_ch1 && !(pl_nxt == dcil_pkg::PL_LOCK && !aff_ch2_nxt);
	assign out2_nxt = active && safety_in_ch2 && !(pl_nxt == dcil_pkg::PL_LOCK && aff_ch2_nxt);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pl_r           <= dcil_pkg::PL_NORMAL;
			aff_ch2_r      <= 1'b0;
			in1_r          <= 1'b0;
			in2_r          <= 1'b0;
			safety_out_ch1 <= 1'b0;
			safety_out_ch2 <= 1'b0;
		end
		else
		begin
			pl_r           <= pl_nxt;
			aff_ch2_r      <= aff_ch2_nxt;
			in1_r          <= safety_in_ch1;
			in2_r          <= safety_in_ch2;
			safety_out_ch1 <= out1_nxt;
			safety_out_ch2 <= out2_nxt;
		end
	end

	// ----------------------------------------
	// Indicator flash divider
	// ----------------------------------------
	always_ff @(posedge sys_clk)
	begin
		if (rst || pl_r == dcil_pkg::PL_NORMAL)
		begin
			flash_cnt_r <= 25'h0000000;
			blink_r     <= 1'b0;
		end
		else if (flash_cnt_r == 25'(FLASH_CYC - 1))
		begin
			flash_cnt_r <= 25'h0000000;
			blink_r     <= !blink_r;
		end
		else
			flash_cnt_r <= flash_cnt_r + 25'h0000001;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			input_led_flash <= 1'b0;
			plaus_error     <= 1'b0;
			status_diag_out <= 1'b0;
		end
		else
		begin
			input_led_flash <= (pl_r != dcil_pkg::PL_NORMAL) && !blink_r;
			plaus_error     <= (pl_nxt == dcil_pkg::PL_LOCK);
			// Diagnostic answer owns the line only while it is sent
			status_diag_out <= tx_active ? tx_bit : active;
		end
	end

	// ----------------------------------------
	// Diagnostics path
	// ----------------------------------------
	assign diag_in_en = serial_diag_option;

	dcil_diag #(
		.BIT_CYC(BIT_CYC)
	) u_diag (
		.sys_clk      (sys_clk),
		.rst          (rst),
		.enable       (serial_diag_option),
		.diag_in      (diag_in),
		.chain_addr   (chain_addr),
		.serial_num   (SERIAL_NO),
		.teach_left   (teach_left),
		.actuator_name(actuator_name),
		.sw_status    ({4'h0, plaus_error, actuator_present, safety_out_ch2, safety_out_ch1}),
		.tx_out       (tx_bit),
		.tx_active    (tx_active)
	);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	// First cycle after reset still shows reset values against pre-reset $past
	always_ff @(posedge sys_clk)
		rst_d_r <= rst;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst || rst_d_r);

	safe_off_a: assert property (!$past(active) |-> !safety_out_ch1 && !safety_out_ch2)
		else $error("safety output high without actuator or ready");
	follow_ch1_a: assert property ($past(active) && $past(pl_nxt) == dcil_pkg::PL_NORMAL
		|-> safety_out_ch1 == $past(safety_in_ch1))
		else $error("channel 1 output does not follow its input");
	follow_ch2_a: assert property ($past(active) && $past(pl_nxt) == dcil_pkg::PL_NORMAL
		|-> safety_out_ch2 == $past(safety_in_ch2))
		else $error("channel 2 output does not follow its input");
	ready_gate_a: assert property (!device_ready |=> !safety_out_ch1 && !safety_out_ch2)
		else $error("output high while not ready");
	unequal_flag_a: assert property (pl_r == dcil_pkg::PL_NORMAL && (fall1 || fall2)
		|=> pl_r == dcil_pkg::PL_UNEQUAL ##1 input_led_flash)
		else $error("unequal inputs not flagged");
	plaus_lock_a: assert property (pl_r == dcil_pkg::PL_UNEQUAL && safety_in_ch1 && safety_in_ch2
		|=> plaus_error && pl_r == dcil_pkg::PL_LOCK)
		else $error("plausibility error not raised");
	lock_hold_a: assert property (pl_r == dcil_pkg::PL_LOCK && !both_low
		|=> (aff_ch2_r ? !safety_out_ch2 : !safety_out_ch1))
		else $error("affected output released during lock");
	rearm_a: assert property (pl_r != dcil_pkg::PL_NORMAL && both_low |=> pl_r == dcil_pkg::PL_NORMAL)
		else $error("no rearm after both inputs low");
	status_a: assert property (!tx_active |=> status_diag_out == $past(active))
		else $error("status output does not show actuator");
	diag_en_a: assert property (!serial_diag_option && !$past(serial_diag_option) |-> !tx_active)
		else $error("diagnostic answer without fieldbus module");
	flash_off_a: assert property (pl_r == dcil_pkg::PL_NORMAL && $past(pl_r) == dcil_pkg::PL_NORMAL
		|-> !input_led_flash)
		else $error("input indicator flashing in normal state");
	status_low_a: assert property (!$past(active) && !$past(tx_active) |-> !status_diag_out)
		else $error("status output high without actuator");
	lock_other_a: assert property ($past(active) && $past(pl_nxt) == dcil_pkg::PL_LOCK
		|-> (aff_ch2_r ? safety_out_ch1 == $past(safety_in_ch1) : safety_out_ch2 == $past(safety_in_ch2)))
		else $error("unaffected channel blocked during lock");

	lock_seen_c: cover property (pl_r == dcil_pkg::PL_UNEQUAL ##1 pl_r == dcil_pkg::PL_LOCK);
	rearm_seen_c: cover property (pl_r == dcil_pkg::PL_LOCK ##1 pl_r == dcil_pkg::PL_NORMAL);
	both_on_c: cover property (safety_out_ch1 && safety_out_ch2 && status_diag_out);
	diag_tx_c: cover property ($rose(tx_active));
endmodule
`default_nettype wire

// ==== tb/dcil_fieldbus_model.sv ====
// Fieldbus module model: command frames out, answer frames in
`timescale 1ns/1ns
`default_nettype none
module dcil_fieldbus_model #(
	parameter int BIT_CYC = 8
) (
	input  wire logic sys_clk,         // System clock
	input  wire logic status_diag_out, // Answer line
	output logic      diag_in          // Command line, idle high
);
	initial diag_in = 1'b1;
	// Start bit, op and address LSB first, then back to idle high
	task automatic send_cmd(input logic [3:0] op, input logic [3:0] addr);
		logic [8:0] bits;
		bits = {addr, op, 1'b0};
		@(posedge sys_clk);
		for (int i = 0; i < 9; i++)
		begin
			diag_in <= bits[i];
			repeat (BIT_CYC) @(posedge sys_clk);
		end
		diag_in <= 1'b1;
	endtask
	// Bounded wait for a start bit, then mid-bit sampling
	task automatic get_rsp(output logic seen, output logic [15:0] data);
		int n;
		seen = 1'b0;
		data = 16'h0000;
		n = 0;
		while (!seen && n < 6 * BIT_CYC)
		begin
			@(posedge sys_clk);
			n++;
			seen = (status_diag_out === 1'b0);
		end
		if (seen)
		begin
			repeat (BIT_CYC / 2) @(posedge sys_clk);
			for (int i = 0; i < 16; i++)
			begin
				repeat (BIT_CYC) @(posedge sys_clk);
				data[i] = status_diag_out;
			end
			repeat (BIT_CYC) @(posedge sys_clk);
			seen = (status_diag_out === 1'b1);
		end
	endtask
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
// Self-checking bench for the dual-channel interlock logic
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	localparam logic [15:0] SER = 16'hC3A1; // Arbitrary value
	logic        sys_clk, rst, safety_in_ch1, safety_in_ch2, actuator_present, device_ready;
	logic        serial_diag_option, diag_in, seen, a, b;
	logic        safety_out_ch1, safety_out_ch2, status_diag_out, input_led_flash, plaus_error, diag_in_en;
	logic [3:0]  chain_addr, k;
	logic [7:0]  teach_left;
	logic [15:0] actuator_name, rsp;
	logic [3:0]  ops [5] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h0};
	int          fails = 0;
	int          checks_done = 0;
	int          n;

	dcil_top #(.FLASH_CYC(4), .BIT_CYC(8), .SERIAL_NO(SER)) u_dcil_top (.sys_clk, .rst, .safety_in_ch1,
		.safety_in_ch2, .actuator_present, .device_ready, .serial_diag_option, .diag_in, .chain_addr,
		.teach_left, .actuator_name, .safety_out_ch1, .safety_out_ch2, .status_diag_out, .input_led_flash,
		.plaus_error, .diag_in_en);
	dcil_fieldbus_model #(.BIT_CYC(8)) u_dcil_fieldbus_model (.sys_clk, .status_diag_out, .diag_in);

	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic drive(input logic r, input logic p, input logic x1, input logic x2);
		@(posedge sys_clk);
		device_ready <= r;
		actuator_present <= p;
		safety_in_ch1 <= x1;
		safety_in_ch2 <= x2;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask

	// Gap after the stop bit keeps the next command off a running answer
	task automatic ask(input logic [3:0] op, input logic [3:0] addr);
		u_dcil_fieldbus_model.send_cmd(op, addr);
		u_dcil_fieldbus_model.get_rsp(seen, rsp);
		repeat (8) @(posedge sys_clk);
	endtask

	function automatic logic [15:0] outs();
		return {13'h0000, status_diag_out, safety_out_ch2, safety_out_ch1};
	endfunction

	function automatic logic [15:0] outs_exp(input logic r, input logic p, input logic x1, input logic x2);
		return {13'h0000, r & p, r & p & x2, r & p & x1};
	endfunction

	// Status word assumes no lock, actuator present and both outputs on
	function automatic logic [15:0] rsp_exp(input logic [3:0] op);
		case (op)
			dcil_pkg::OP_SERIAL: return SER;
			dcil_pkg::OP_TEACH:  return {8'h00, teach_left};
			dcil_pkg::OP_NAME:   return actuator_name;
			default:             return 16'h0007;
		endcase
	endfunction

	initial
	begin
		#200000;
		fails++;
		report_and_stop();
	end

	initial
	begin
		rst = 1'b1;
		{safety_in_ch1, safety_in_ch2, actuator_present, device_ready, serial_diag_option} = 5'h00;
		{chain_addr, teach_left, actuator_name} = 28'h0000000;
		void'($urandom(32'h36B9A585));
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1;
		chk(outs(), 16'h0000, "after reset");
		// Every input combination first, then random ones
		for (int i = 0; i < 48; i++)
		begin
			k = (i < 16) ? 4'(i) : 4'($urandom);
			drive(k[3], k[2], 1'b0, 1'b0);
			chk(outs(), outs_exp(k[3], k[2], 1'b0, 1'b0), "both low");
			drive(k[3], k[2], k[0], k[1]);
			chk(outs(), outs_exp(k[3], k[2], k[0], k[1]), "rise");
		end
		for (int c = 0; c < 2; c++)
		begin
			a = (c != 0);
			b = (c != 1);
			drive(1'b1, 1'b1, 1'b1, 1'b1);
			drive(1'b1, 1'b1, a, b);
			chk(outs(), outs_exp(1'b1, 1'b1, a, b), "unequal");
			n = 0;
			while (input_led_flash !== 1'b1 && n < 20)
			begin
				@(posedge sys_clk);
				n++;
			end
			chk(16'(input_led_flash), 16'h0001, "flash");
			drive(1'b1, 1'b1, 1'b1, 1'b1);
			chk(16'(plaus_error), 16'h0001, "lock");
			repeat (10) @(posedge sys_clk);
			chk(outs(), outs_exp(1'b1, 1'b1, a, b), "locked");
			drive(1'b1, 1'b1, 1'b0, 1'b0);
			chk(16'(plaus_error), 16'h0000, "unlock");
			drive(1'b1, 1'b1, 1'b1, 1'b1);
			chk(outs(), 16'h0007, "resume");
			repeat (4) @(posedge sys_clk);
			chk(16'(input_led_flash), 16'h0000, "flash off");
		end
		@(posedge sys_clk);
		chain_addr <= 4'($urandom);
		teach_left <= 8'($urandom);
		actuator_name <= 16'($urandom);
		@(posedge sys_clk);
		#1;
		chk(16'(diag_in_en), 16'h0000, "diag off");
		ask(dcil_pkg::OP_SERIAL, chain_addr);
		chk(16'(seen), 16'h0000, "unused input");
		chk(outs(), 16'h0007, "status");
		serial_diag_option <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		chk(16'(diag_in_en), 16'h0001, "diag on");
		for (int j = 0; j < 10; j++)
		begin
			if (j == 5)
			begin
				@(posedge sys_clk);
				chain_addr <= 4'hF;
				@(posedge sys_clk);
			end
			ask(ops[j % 5], chain_addr);
			chk(16'(seen), 16'h0001, "answer seen");
			chk(rsp, rsp_exp(ops[j % 5]), "answer");
		end
		ask(dcil_pkg::OP_SERIAL, chain_addr + 4'h1);
		chk(16'(seen), 16'h0000, "other address");
		rst <= 1'b1;
		repeat (3) @(posedge sys_clk);
		#1;
		chk(outs(), 16'h0000, "in reset");
		@(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		ask(dcil_pkg::OP_NAME, chain_addr);
		chk(16'(seen), 16'h0001, "restart seen");
		chk(rsp, actuator_name, "after restart");
		report_and_stop();
	end
endmodule
`default_nettype wire
